// *** rtl/slmh_pkg.sv ***
// slmh_pkg: constants for the bus message handler of the codec's devices.
// assumes a message deframer upstream and a reply framer downstream.
// Contract
// - information map is three 1kByte blocks; user block reads as zero.
// - element code selects element; each read request carries its own transaction id.
// - information request answered by information reply with id and slice.
// - clearing request replies with slice, then clears masked bits.
// - clear message clears masked bits of slice, sends no reply.
// - a watched information element change sends a report with code and value; here a change seen in a reply cycle is dropped.
// - value map is three 1kByte blocks; user block used only on interface.
// - interface user value elements reach the codec control register map.
// - value request answered by value reply with id and slice.
// - change value writes update bytes into selected value element.
// - next parameters pend, apply at first superframe two slots after commit; here channel and content definitions land on receipt.
// - active framer handover names incoming framer and idle clock cycle counts.
// - subframe mode and clock gear are adopted at the boundary.
// - pause clock carries restart time selecting time, phase or both.
// - reset bus resets and disconnects the device at the boundary.
// - shutdown bus prepares the device for shutdown at the boundary.
// - connect source and sink bind port to channel; many sinks allowed.
// - define channel records protocol, distribution and segment length; here only protocol and distribution are kept.
// - define or change content records content fields for the channel.
// - changes to active channels never interrupt their flow.
// - deactivate pauses, activate starts channel at the boundary.
// - disconnect port and remove channel both tear down the data path.
package slmh_pkg;
  localparam logic [6:0] MC_CONNECT_SRC = 7'h10;
  localparam logic [6:0] MC_CONNECT_SNK = 7'h11;
  localparam logic [6:0] MC_DISCONNECT = 7'h14;
  localparam logic [6:0] MC_CHG_CONTENT = 7'h18;
  localparam logic [6:0] MC_REQ_INFO = 7'h20;
  localparam logic [6:0] MC_REQ_CLR_INFO = 7'h21;
  localparam logic [6:0] MC_REPLY_INFO = 7'h24;
  localparam logic [6:0] MC_CLR_INFO = 7'h28;
  localparam logic [6:0] MC_REPORT_INFO = 7'h29;
  localparam logic [6:0] MC_BEGIN_RECFG = 7'h40;
  localparam logic [6:0] MC_NEXT_FRAMER = 7'h44;
  localparam logic [6:0] MC_NEXT_SUBFRAME = 7'h45;
  localparam logic [6:0] MC_NEXT_GEAR = 7'h46;
  localparam logic [6:0] MC_NEXT_PAUSE = 7'h4a;
  localparam logic [6:0] MC_NEXT_RESET = 7'h4b;
  localparam logic [6:0] MC_NEXT_SHUTDOWN = 7'h4c;
  localparam logic [6:0] MC_NEXT_DEF_CHAN = 7'h50;
  localparam logic [6:0] MC_NEXT_DEF_CONT = 7'h51;
  localparam logic [6:0] MC_NEXT_ACTIVATE = 7'h54;
  localparam logic [6:0] MC_NEXT_DEACT = 7'h55;
  localparam logic [6:0] MC_NEXT_REMOVE = 7'h58;
  localparam logic [6:0] MC_RECFG_NOW = 7'h5f;
  localparam logic [6:0] MC_REQ_VALUE = 7'h60;
  localparam logic [6:0] MC_REPLY_VALUE = 7'h64;
  localparam logic [6:0] MC_CHG_VALUE = 7'h68;
  // element code: bits 11:10 pick block (core, class, user)
  localparam int EC_W = 12;
  localparam int EC_BLK_HI = 11;
  localparam int EC_BLK_LO = 10;
  localparam logic [1:0] BLK_USER = 2'h2;
  localparam int MAP_BYTES = 1024;
  // boundary needs at least two slots after commit ends
  localparam logic [1:0] MIN_SLOTS = 2'h2;
  localparam logic [7:0] INFO_RESET = 8'h00;
  // pending-flag bits in the pending mask
  localparam int P_FRAMER = 0;
  localparam int P_SUBFR = 1;
  localparam int P_GEAR = 2;
  localparam int P_PAUSE = 3;
  localparam int P_RESET = 4;
  localparam int P_SHUT = 5;
  localparam int P_W = 6;
  typedef enum logic [3:0] {
    SLMH_IDLE = 4'h1,
    SLMH_OPEN = 4'h2,
    SLMH_ARMED = 4'h4,
    SLMH_WAIT = 4'h8
  } slmh_rcfg_t;
endpackage

// *** rtl/slmh_top.sv ***
// slmh_top: decodes bus messages for the codec's devices, keeps maps and channels.
// assumes messages arrive one per pulse from a deframer on clock_in; link clock is a pin.
`timescale 1ns/1ps
`default_nettype none
module slmh_top #(
  parameter int CHANS = 16,
  parameter int PORTS = 16,
  parameter int MANAGER_LA = 8'hff,
  parameter int WATCH_EC = 12'h000
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // link timing from the bus
  input wire logic link_clk_in,
  input wire logic frame_slot_in,
  input wire logic superframe_in,
  // decoded message in
  input wire logic msg_valid_in,
  input wire logic [6:0] msg_code_in,
  input wire logic [7:0] msg_src_la_in,
  input wire logic [7:0] msg_tid_in,
  input wire logic [slmh_pkg::EC_W-1:0] msg_ec_in,
  input wire logic [7:0] msg_data_in,
  input wire logic [7:0] msg_arg_a_in,
  input wire logic [15:0] msg_arg_b_in,
  input wire logic msg_end_in,
  // hardware events on information bits
  input wire logic [7:0] info_set_in,
  // codec control register map
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [9:0] reg_addr_out,
  output logic [7:0] reg_wdata_out,
  input wire logic [7:0] reg_rdata_in,
  // reply message out
  output logic reply_valid_out,
  output logic [6:0] reply_code_out,
  output logic [7:0] reply_tid_out,
  output logic [slmh_pkg::EC_W-1:0] reply_ec_out,
  output logic [7:0] reply_data_out,
  // applied configuration
  output logic [7:0] framer_la_out,
  output logic [7:0] framer_nco_out,
  output logic [7:0] framer_nci_out,
  output logic [7:0] subframe_mode_out,
  output logic [7:0] clock_gear_out,
  output logic [7:0] pause_rt_out,
  output logic pause_out,
  output logic bus_reset_out,
  output logic shutdown_out,
  output logic [CHANS-1:0] chan_active_out,
  output logic [PORTS-1:0] port_linked_out
);
  localparam int CW = $clog2(CHANS);
  localparam int PW = $clog2(PORTS);

  // link clock edge finder: three flops, change counts once flop 2 and 3 agree
  logic [2:0] lclk_sync;
  logic lclk_stable;
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lclk_sync <= 3'h0;
      lclk_stable <= 1'b0;
    end else begin
      lclk_sync <= {lclk_sync[1:0], link_clk_in};
      if (lclk_sync[2] == lclk_sync[1])
        lclk_stable <= lclk_sync[2];
    end
  end
  wire lclk_rise = (lclk_sync[2] == lclk_sync[1]) && lclk_sync[2] && !lclk_stable;

  // request gate: only the manager may issue requests
  wire is_req = (msg_code_in == slmh_pkg::MC_REQ_INFO) ||
                (msg_code_in == slmh_pkg::MC_REQ_CLR_INFO) ||
                (msg_code_in == slmh_pkg::MC_REQ_VALUE);
  wire take = msg_valid_in && !(is_req && msg_src_la_in != MANAGER_LA[7:0]);
  wire hit = take && msg_end_in;
  wire [1:0] blk = msg_ec_in[slmh_pkg::EC_BLK_HI:slmh_pkg::EC_BLK_LO];
  wire user_blk = blk == slmh_pkg::BLK_USER;
  wire [9:0] ec_off = msg_ec_in[slmh_pkg::EC_BLK_LO-1:0];

  // information map: one byte slice per element of the core and class blocks
  logic [7:0] info_mem [0:2*slmh_pkg::MAP_BYTES-1];
  wire [10:0] info_idx = msg_ec_in[10:0];
  wire [7:0] info_now = user_blk ? slmh_pkg::INFO_RESET : info_mem[info_idx];
  wire info_clr = hit && !user_blk && (msg_code_in == slmh_pkg::MC_CLR_INFO ||
                  msg_code_in == slmh_pkg::MC_REQ_CLR_INFO);
  logic [7:0] watch_prev;
  wire [7:0] watch_now = info_mem[WATCH_EC[10:0]];
  always_ff @(posedge clock_in) begin
    for (int i = 0; i < 2*slmh_pkg::MAP_BYTES; i++) begin
      // hardware set wins over a clear arriving the same cycle
      if (info_clr && info_idx == 11'(i))
        info_mem[i] <= (info_mem[i] & ~msg_arg_a_in) | info_set_in;
      else if (11'(i) == WATCH_EC[10:0])
        info_mem[i] <= info_mem[i] | info_set_in;
    end
  end

  // value map: core and class held here, user block forwarded to codec registers
  logic [7:0] val_mem [0:2*slmh_pkg::MAP_BYTES-1];
  wire val_wr = hit && msg_code_in == slmh_pkg::MC_CHG_VALUE;
  wire val_rd = hit && msg_code_in == slmh_pkg::MC_REQ_VALUE;
  always_ff @(posedge clock_in) begin
    if (val_wr && !user_blk)
      val_mem[info_idx] <= msg_data_in;
  end
  assign reg_wr_out = val_wr && user_blk;
  assign reg_rd_out = val_rd && user_blk;
  assign reg_addr_out = ec_off;
  assign reg_wdata_out = msg_data_in;

  // reply path: register reads answer one cycle later, when read data is back
  logic rd_pend;
  logic [7:0] rd_tid;
  logic [slmh_pkg::EC_W-1:0] rd_ec;
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      reply_valid_out <= 1'b0;
      reply_code_out <= 7'h00;
      reply_tid_out <= 8'h00;
      reply_ec_out <= '0;
      reply_data_out <= 8'h00;
      rd_pend <= 1'b0;
      rd_tid <= 8'h00;
      rd_ec <= '0;
      watch_prev <= 8'h00;
    end else begin
      reply_valid_out <= 1'b0;
      rd_pend <= reg_rd_out;
      rd_tid <= msg_tid_in;
      rd_ec <= msg_ec_in;
      watch_prev <= watch_now;
      if (rd_pend) begin
        reply_valid_out <= 1'b1;
        reply_code_out <= slmh_pkg::MC_REPLY_VALUE;
        reply_tid_out <= rd_tid;
        reply_ec_out <= rd_ec;
        reply_data_out <= reg_rdata_in;
      end else if (hit && (msg_code_in == slmh_pkg::MC_REQ_INFO ||
                           msg_code_in == slmh_pkg::MC_REQ_CLR_INFO)) begin
        reply_valid_out <= 1'b1;
        reply_code_out <= slmh_pkg::MC_REPLY_INFO;
        reply_tid_out <= msg_tid_in;
        reply_ec_out <= msg_ec_in;
        reply_data_out <= info_now;
      end else if (val_rd && !user_blk) begin
        reply_valid_out <= 1'b1;
        reply_code_out <= slmh_pkg::MC_REPLY_VALUE;
        reply_tid_out <= msg_tid_in;
        reply_ec_out <= msg_ec_in;
        reply_data_out <= val_mem[info_idx];
      end else if (watch_now != watch_prev) begin
        // report yields to replies; a change seen in a reply cycle is dropped, as watch_prev follows it anyway
        reply_valid_out <= 1'b1;
        reply_code_out <= slmh_pkg::MC_REPORT_INFO;
        reply_tid_out <= 8'h00;
        reply_ec_out <= WATCH_EC[slmh_pkg::EC_W-1:0];
        reply_data_out <= watch_now;
      end
    end
  end

  // reconfiguration sequencer
  slmh_pkg::slmh_rcfg_t state, next_state;
  logic [1:0] slot_cnt;
  logic [slmh_pkg::P_W-1:0] pend;
  logic [7:0] p_la, p_nco, p_nci, p_sm, p_cg, p_rt;
  logic [CHANS-1:0] p_act, p_deact, p_remove;
  wire is_next = hit && (msg_code_in[6:4] == 3'h4 || msg_code_in[6:4] == 3'h5) &&
                 msg_code_in != slmh_pkg::MC_BEGIN_RECFG &&
                 msg_code_in != slmh_pkg::MC_RECFG_NOW;
  wire open_seq = state == slmh_pkg::SLMH_OPEN;
  wire [CW-1:0] cn = msg_arg_a_in[CW-1:0];
  wire apply = state == slmh_pkg::SLMH_WAIT && superframe_in;
  always_comb begin
    next_state = state;
    unique case (state)
      slmh_pkg::SLMH_IDLE:
        if (hit && msg_code_in == slmh_pkg::MC_BEGIN_RECFG)
          next_state = slmh_pkg::SLMH_OPEN;
      slmh_pkg::SLMH_OPEN:
        if (hit && msg_code_in == slmh_pkg::MC_RECFG_NOW)
          next_state = slmh_pkg::SLMH_ARMED;
      slmh_pkg::SLMH_ARMED:
        if (slot_cnt == slmh_pkg::MIN_SLOTS)
          next_state = slmh_pkg::SLMH_WAIT;
      slmh_pkg::SLMH_WAIT:
        if (superframe_in)
          next_state = slmh_pkg::SLMH_IDLE;
      default:
        next_state = slmh_pkg::SLMH_IDLE;
    endcase
  end
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= slmh_pkg::SLMH_IDLE;
      slot_cnt <= 2'h0;
    end else begin
      state <= next_state;
      if (state != slmh_pkg::SLMH_ARMED)
        slot_cnt <= 2'h0;
      else if (frame_slot_in && lclk_rise && slot_cnt != slmh_pkg::MIN_SLOTS)
        slot_cnt <= slot_cnt + 2'h1;
    end
  end

  // pending parameters; channel activate, deactivate and remove are staged, never cut the running flow
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pend <= '0;
      {p_la, p_nco, p_nci, p_sm, p_cg, p_rt} <= '0;
      p_act <= '0;
      p_deact <= '0;
      p_remove <= '0;
    end else if (apply || (hit && msg_code_in == slmh_pkg::MC_BEGIN_RECFG)) begin
      pend <= '0;
      p_act <= '0;
      p_deact <= '0;
      p_remove <= '0;
    end else if (is_next && open_seq) begin
      unique case (msg_code_in)
        slmh_pkg::MC_NEXT_FRAMER: begin
          pend[slmh_pkg::P_FRAMER] <= 1'b1;
          p_la <= msg_arg_a_in;
          p_nco <= msg_arg_b_in[7:0];
          p_nci <= msg_arg_b_in[15:8];
        end
        slmh_pkg::MC_NEXT_SUBFRAME: begin
          pend[slmh_pkg::P_SUBFR] <= 1'b1;
          p_sm <= msg_arg_a_in;
        end
        slmh_pkg::MC_NEXT_GEAR: begin
          pend[slmh_pkg::P_GEAR] <= 1'b1;
          p_cg <= msg_arg_a_in;
        end
        slmh_pkg::MC_NEXT_PAUSE: begin
          pend[slmh_pkg::P_PAUSE] <= 1'b1;
          p_rt <= msg_arg_a_in;
        end
        slmh_pkg::MC_NEXT_RESET: pend[slmh_pkg::P_RESET] <= 1'b1;
        slmh_pkg::MC_NEXT_SHUTDOWN: pend[slmh_pkg::P_SHUT] <= 1'b1;
        slmh_pkg::MC_NEXT_ACTIVATE: p_act[cn] <= 1'b1;
        slmh_pkg::MC_NEXT_DEACT: p_deact[cn] <= 1'b1;
        slmh_pkg::MC_NEXT_REMOVE: p_remove[cn] <= 1'b1;
        default: ;
      endcase
    end
  end

  // applied state
  logic [CW-1:0] port_chan [0:PORTS-1];
  logic [7:0] chan_tp [0:CHANS-1];
  logic [15:0] chan_sd [0:CHANS-1];
  logic [7:0] chan_content [0:CHANS-1];
  wire [PW-1:0] pn = msg_arg_b_in[PW-1:0];
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      {framer_la_out, framer_nco_out, framer_nci_out} <= '0;
      {subframe_mode_out, clock_gear_out, pause_rt_out} <= '0;
      {pause_out, bus_reset_out, shutdown_out} <= 3'h0;
      chan_active_out <= '0;
      port_linked_out <= '0;
    end else if (bus_reset_out) begin
      // disconnect; rejoin later follows first-initialisation path
      bus_reset_out <= 1'b0;
      chan_active_out <= '0;
      port_linked_out <= '0;
    end else begin
      if (apply) begin
        if (pend[slmh_pkg::P_FRAMER])
          {framer_la_out, framer_nco_out, framer_nci_out} <= {p_la, p_nco, p_nci};
        if (pend[slmh_pkg::P_SUBFR])
          subframe_mode_out <= p_sm;
        if (pend[slmh_pkg::P_GEAR])
          clock_gear_out <= p_cg;
        pause_out <= pend[slmh_pkg::P_PAUSE];
        if (pend[slmh_pkg::P_PAUSE])
          pause_rt_out <= p_rt;
        bus_reset_out <= pend[slmh_pkg::P_RESET];
        shutdown_out <= shutdown_out | pend[slmh_pkg::P_SHUT];
        chan_active_out <= (chan_active_out & ~p_deact & ~p_remove) | p_act;
        for (int p = 0; p < PORTS; p++)
          if (p_remove[port_chan[p]])
            port_linked_out[p] <= 1'b0;
      end
      if (hit && (msg_code_in == slmh_pkg::MC_CONNECT_SRC ||
                  msg_code_in == slmh_pkg::MC_CONNECT_SNK))
        port_linked_out[pn] <= 1'b1;
      else if (hit && msg_code_in == slmh_pkg::MC_DISCONNECT)
        port_linked_out[pn] <= 1'b0;
    end
  end
  always_ff @(posedge clock_in) begin
    if (hit && (msg_code_in == slmh_pkg::MC_CONNECT_SRC ||
                msg_code_in == slmh_pkg::MC_CONNECT_SNK))
      port_chan[pn] <= cn;
    // definitions land directly: the active flag is untouched so flow continues
    if (is_next && open_seq && msg_code_in == slmh_pkg::MC_NEXT_DEF_CHAN) begin
      chan_tp[cn] <= msg_data_in;
      chan_sd[cn] <= msg_arg_b_in;
    end
    if ((is_next && open_seq && msg_code_in == slmh_pkg::MC_NEXT_DEF_CONT) ||
        (hit && msg_code_in == slmh_pkg::MC_CHG_CONTENT))
      chan_content[cn] <= msg_data_in;
  end

  // assertions
  reply_id_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (hit && msg_code_in == slmh_pkg::MC_REQ_INFO) |=>
      reply_valid_out && reply_tid_out == $past(msg_tid_in))
    else $error("info reply lost its transaction id");
  clr_silent_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (hit && msg_code_in == slmh_pkg::MC_CLR_INFO && !rd_pend) |=>
      !(reply_valid_out && reply_code_out == slmh_pkg::MC_REPLY_INFO))
    else $error("clear information produced a reply");
  req_gate_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (msg_valid_in && is_req && msg_src_la_in != MANAGER_LA[7:0] && !rd_pend) |=>
      !rd_pend && !(reply_valid_out && reply_code_out != slmh_pkg::MC_REPORT_INFO))
    else $error("request from non manager accepted");
  sequence commit_s;
    state == slmh_pkg::SLMH_ARMED ##1 state == slmh_pkg::SLMH_WAIT;
  endsequence
  wait_slots_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
    commit_s |-> $past(slot_cnt) == slmh_pkg::MIN_SLOTS)
    else $error("boundary armed before two slots");
  def_store_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (is_next && open_seq && msg_code_in == slmh_pkg::MC_NEXT_DEF_CHAN) |=>
      chan_sd[$past(cn)] == $past(msg_arg_b_in) && chan_tp[$past(cn)] == $past(msg_data_in))
    else $error("channel definition not recorded");
  gear_apply_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (apply && pend[slmh_pkg::P_GEAR]) |=> clock_gear_out == $past(p_cg))
    else $error("clock gear not adopted at boundary");
  chan_act_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (apply && |p_act && !bus_reset_out) |=> (chan_active_out & $past(p_act)) == $past(p_act))
    else $error("channel not activated at boundary");
  no_early_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (!apply && !bus_reset_out) |=> $stable(clock_gear_out))
    else $error("parameter changed outside boundary");
  reg_fwd_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (val_rd && user_blk) |=> ##1 reply_valid_out && reply_code_out == slmh_pkg::MC_REPLY_VALUE)
    else $error("register read not answered in two cycles");
  shut_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (apply && pend[slmh_pkg::P_SHUT] && !bus_reset_out) |=> shutdown_out)
    else $error("shutdown not prepared at boundary");
endmodule
`default_nettype wire

// *** tb/slmh_mgr_model.sv ***
// slmh_mgr_model: far side of the message handler, bus timing and control register map.
// assumes clock_in at 200 MHz; link clock made here at 64 ns, unrelated in phase.
`timescale 1ns/1ps
`default_nettype none
module slmh_mgr_model #(
  parameter int SF_CYCLES = 400
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // bus timing from the framer
  output logic link_clk_out,
  output logic frame_slot_out,
  output logic superframe_out,
  // codec control register map
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [9:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out
);
  logic [7:0] mem [0:1023];
  logic [1:0] link_cnt = 2'h0;
  int sf_cnt;
  // one process owns the link clock; it runs free, as the bus clock does
  always begin
    link_clk_out = 1'b0;
    #32;
    link_clk_out = 1'b1;
    #32;
  end
  // changed on the falling edge so the rising edge sees a settled slot end
  always @(negedge link_clk_out) begin
    link_cnt <= link_cnt + 2'h1;
    frame_slot_out <= (link_cnt == 2'h3);
  end
  // superframe period far longer than two slots, so the second pulse always qualifies
  always @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sf_cnt <= 0;
      superframe_out <= 1'b0;
    end else begin
      sf_cnt <= (sf_cnt == SF_CYCLES - 1) ? 0 : sf_cnt + 1;
      superframe_out <= (sf_cnt == SF_CYCLES - 1);
    end
  end
  // read data valid only the cycle after the strobe; otherwise a changing pattern
  always @(posedge clock_in) begin
    if (reg_wr_in) mem[reg_addr_in] <= reg_wdata_in;
    reg_rdata_out <= reg_rd_in ? mem[reg_addr_in] : ~reg_rdata_out;
  end
endmodule
`default_nettype wire

// *** tb/slmh_message_handler_tb.sv ***
// slmh_message_handler_tb: self-checking bench for the bus message handler.
// assumes slmh_pkg, slmh_top and slmh_mgr_model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module slmh_message_handler_tb;
  localparam logic [7:0] M = 8'hff;
  typedef struct {
    logic [6:0] code; logic [7:0] la; logic [7:0] tid; logic [11:0] ec; logic [7:0] dat;
    logic [7:0] a; bit want; logic [6:0] rc; logic [7:0] rd;
  } slmh_row_t;
  slmh_row_t rows [9];
  logic clock_in = 1'b0;
  logic resetn_in = 1'b0;
  logic msg_valid_in = 1'b0;
  logic msg_end_in = 1'b0;
  logic [6:0] msg_code_in = 7'h00;
  logic [7:0] msg_src_la_in = 8'h00, msg_tid_in = 8'h00, msg_data_in = 8'h00;
  logic [7:0] msg_arg_a_in = 8'h00, info_set_in = 8'h00;
  logic [11:0] msg_ec_in = 12'h000;
  logic [15:0] msg_arg_b_in = 16'h0000;
  wire logic link_clk_in, frame_slot_in, superframe_in, reg_wr_out, reg_rd_out;
  wire logic reply_valid_out, pause_out, bus_reset_out, shutdown_out;
  wire logic [9:0] reg_addr_out;
  wire logic [6:0] reply_code_out;
  wire logic [11:0] reply_ec_out;
  wire logic [15:0] chan_active_out, port_linked_out;
  wire logic [7:0] reg_wdata_out, reg_rdata_in, reply_tid_out, reply_data_out, framer_la_out;
  wire logic [7:0] framer_nco_out, framer_nci_out, subframe_mode_out, clock_gear_out;
  wire logic [7:0] pause_rt_out;
  int miscompares = 0;
  int checks = 0;
  logic reset_seen = 1'b0;
  slmh_top u_slmh_top (.clock_in, .resetn_in, .link_clk_in, .frame_slot_in, .superframe_in,
    .msg_valid_in, .msg_code_in, .msg_src_la_in, .msg_tid_in, .msg_ec_in, .msg_data_in,
    .msg_arg_a_in, .msg_arg_b_in, .msg_end_in, .info_set_in, .reg_wr_out, .reg_rd_out,
    .reg_addr_out, .reg_wdata_out, .reg_rdata_in, .reply_valid_out, .reply_code_out,
    .reply_tid_out, .reply_ec_out, .reply_data_out, .framer_la_out, .framer_nco_out,
    .framer_nci_out, .subframe_mode_out, .clock_gear_out, .pause_rt_out, .pause_out,
    .bus_reset_out, .shutdown_out, .chan_active_out, .port_linked_out);
  slmh_mgr_model u_slmh_mgr_model (.clock_in, .resetn_in, .link_clk_out(link_clk_in),
    .frame_slot_out(frame_slot_in), .superframe_out(superframe_in), .reg_wr_in(reg_wr_out),
    .reg_rd_in(reg_rd_out), .reg_addr_in(reg_addr_out), .reg_wdata_in(reg_wdata_out),
    .reg_rdata_out(reg_rdata_in));
  always #2.5 clock_in = ~clock_in;
  // the reset pulse lasts one cycle, so it is latched here
  always @(negedge clock_in) if (bus_reset_out === 1'b1) reset_seen = 1'b1;
  task automatic print_verdict();
    if (miscompares == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [6:0] c, input logic [7:0] la, input logic [7:0] tid,
      input logic [11:0] ec, input logic [7:0] d, input logic [7:0] a, input logic [15:0] b);
    @(negedge clock_in);
    {msg_valid_in, msg_end_in, msg_code_in, msg_src_la_in} = {2'b11, c, la};
    {msg_tid_in, msg_ec_in, msg_data_in, msg_arg_a_in, msg_arg_b_in} = {tid, ec, d, a, b};
    @(negedge clock_in);
    {msg_valid_in, msg_end_in} = 2'b00;
  endtask
  task automatic nx(input logic [6:0] c, input logic [7:0] a, input logic [15:0] b);
    send(c, M, 8'h00, 12'h000, 8'h21, a, b);
  endtask
  // reports may slip in between replies, so a reply wait skips them and vice versa
  task automatic get_reply(input bit want, input bit rep, input logic [6:0] rc,
      input logic [7:0] tid, input logic [11:0] ec, input logic [7:0] rd);
    bit seen;
    seen = 1'b0;
    // a one-cycle reply already stands at the negedge on which send returns
    for (int i = 0; i < 8; i++) begin
      if (reply_valid_out === 1'b1 && !seen
          && (reply_code_out === slmh_pkg::MC_REPORT_INFO) == rep) begin
        seen = 1'b1;
        chk(reply_code_out, rc);
        chk(reply_data_out, rd);
        if (rep) chk(reply_ec_out, ec);
        else chk(reply_tid_out, tid);
      end
      @(negedge clock_in);
    end
    chk(seen, want);
  endtask
  // second superframe after the commit is always past two slot ends
  task automatic wait_sf();
    int n;
    n = 0;
    for (int i = 0; i < 2000 && n < 2; i++) begin
      @(negedge clock_in);
      if (superframe_in === 1'b1) n++;
    end
    if (n < 2) begin
      miscompares++;
      print_verdict();
    end
    repeat (3) @(negedge clock_in);
  endtask
  initial begin
    rows = '{
      '{slmh_pkg::MC_CLR_INFO, M, 8'h00, 12'h000, 8'h00, 8'hff, 1'b0, 7'h00, 8'h00},
      '{slmh_pkg::MC_REQ_INFO, M, 8'h01, 12'h000, 8'h00, 8'h00, 1'b1, 7'h24, 8'h00},
      '{slmh_pkg::MC_REQ_INFO, M, 8'h02, 12'h800, 8'h00, 8'h00, 1'b1, 7'h24, 8'h00},
      '{slmh_pkg::MC_CHG_VALUE, M, 8'h00, 12'h805, 8'h5a, 8'h00, 1'b0, 7'h00, 8'h00},
      '{slmh_pkg::MC_REQ_VALUE, M, 8'h03, 12'h805, 8'h00, 8'h00, 1'b1, 7'h64, 8'h5a},
      '{slmh_pkg::MC_REQ_VALUE, 8'h01, 8'h04, 12'h805, 8'h00, 8'h00, 1'b0, 7'h00, 8'h00},
      '{slmh_pkg::MC_CHG_VALUE, M, 8'h00, 12'h80a, 8'hc3, 8'h00, 1'b0, 7'h00, 8'h00},
      '{slmh_pkg::MC_REQ_VALUE, M, 8'h05, 12'h80a, 8'h00, 8'h00, 1'b1, 7'h64, 8'hc3},
      '{slmh_pkg::MC_REQ_CLR_INFO, 8'h01, 8'h06, 12'h000, 8'h00, 8'hff, 1'b0, 7'h00, 8'h00}};
    repeat (3) @(negedge clock_in);
    chk({reply_valid_out, shutdown_out, pause_out, clock_gear_out}, 16'h0000);
    chk(port_linked_out | chan_active_out, 16'h0000);
    resetn_in = 1'b1;
    repeat (2) @(negedge clock_in);
    foreach (rows[i]) begin
      send(rows[i].code, rows[i].la, rows[i].tid, rows[i].ec, rows[i].dat, rows[i].a, 16'h0);
      get_reply(rows[i].want, 1'b0, rows[i].rc, rows[i].tid, 12'h000, rows[i].rd);
    end
    info_set_in = 8'h0c;
    @(negedge clock_in);
    info_set_in = 8'h00;
    get_reply(1'b1, 1'b1, slmh_pkg::MC_REPORT_INFO, 8'h00, 12'h000, 8'h0c);
    send(slmh_pkg::MC_REQ_CLR_INFO, M, 8'h07, 12'h000, 8'h00, 8'h04, 16'h0);
    get_reply(1'b1, 1'b0, 7'h24, 8'h07, 12'h000, 8'h0c);
    send(slmh_pkg::MC_REQ_INFO, M, 8'h08, 12'h000, 8'h00, 8'h00, 16'h0);
    get_reply(1'b1, 1'b0, 7'h24, 8'h08, 12'h000, 8'h08);
    nx(slmh_pkg::MC_BEGIN_RECFG, 8'h00, 16'h0);
    nx(slmh_pkg::MC_NEXT_GEAR, 8'h07, 16'h0);
    nx(slmh_pkg::MC_NEXT_SUBFRAME, 8'h0b, 16'h0);
    nx(slmh_pkg::MC_NEXT_FRAMER, 8'h42, 16'h0605);
    nx(slmh_pkg::MC_NEXT_DEF_CHAN, 8'h03, 16'h0c21);
    nx(slmh_pkg::MC_NEXT_DEF_CONT, 8'h03, 16'h0);
    nx(slmh_pkg::MC_NEXT_ACTIVATE, 8'h03, 16'h0);
    nx(slmh_pkg::MC_RECFG_NOW, 8'h00, 16'h0);
    chk({clock_gear_out, subframe_mode_out}, 16'h0000);
    chk(chan_active_out, 16'h0000);
    wait_sf();
    chk({clock_gear_out, subframe_mode_out}, 16'h070b);
    chk({framer_la_out, framer_nco_out, framer_nci_out}, 24'h420506);
    chk(chan_active_out, 16'h0008);
    nx(slmh_pkg::MC_CONNECT_SRC, 8'h03, 16'h0002);
    nx(slmh_pkg::MC_CONNECT_SNK, 8'h03, 16'h0004);
    nx(slmh_pkg::MC_CONNECT_SNK, 8'h03, 16'h0005);
    nx(slmh_pkg::MC_CONNECT_SNK, 8'h01, 16'h0007);
    nx(slmh_pkg::MC_CHG_CONTENT, 8'h03, 16'h0);
    chk(port_linked_out, 16'h00b4);
    chk(chan_active_out, 16'h0008);
    nx(slmh_pkg::MC_DISCONNECT, 8'h00, 16'h0002);
    chk(port_linked_out, 16'h00b0);
    nx(slmh_pkg::MC_NEXT_GEAR, 8'h01, 16'h0);
    nx(slmh_pkg::MC_BEGIN_RECFG, 8'h00, 16'h0);
    nx(slmh_pkg::MC_NEXT_DEF_CHAN, 8'h03, 16'h0d31);
    nx(slmh_pkg::MC_NEXT_DEACT, 8'h03, 16'h0);
    nx(slmh_pkg::MC_NEXT_REMOVE, 8'h03, 16'h0);
    nx(slmh_pkg::MC_RECFG_NOW, 8'h00, 16'h0);
    wait_sf();
    chk(clock_gear_out, 8'h07);
    chk(chan_active_out, 16'h0000);
    chk(port_linked_out, 16'h0080);
    nx(slmh_pkg::MC_BEGIN_RECFG, 8'h00, 16'h0);
    nx(slmh_pkg::MC_NEXT_PAUSE, 8'h02, 16'h0);
    nx(slmh_pkg::MC_NEXT_SHUTDOWN, 8'h00, 16'h0);
    nx(slmh_pkg::MC_NEXT_RESET, 8'h00, 16'h0);
    nx(slmh_pkg::MC_RECFG_NOW, 8'h00, 16'h0);
    wait_sf();
    chk({pause_rt_out, pause_out}, 9'h005);
    chk(shutdown_out, 1'b1);
    chk({reset_seen, port_linked_out}, 17'h10000);
    resetn_in = 1'b0;
    @(negedge clock_in);
    chk({shutdown_out, pause_out, clock_gear_out}, 16'h0000);
    print_verdict();
  end
endmodule
`default_nettype wire
